// ==== mfc_pkg.sv ====
`default_nettype none
package mfc_pkg;

	// ----------------------------------------
	// Time base
	// ----------------------------------------
	localparam int CLK_HZ        = 100_000_000;
	localparam int REF_HZ        = 10_000_000;
	localparam int REF_DIV       = CLK_HZ / REF_HZ;
	localparam int US_HZ         = 1_000_000;
	localparam int US_DIV        = REF_HZ / US_HZ;
	localparam int CENTI_TIME_US = 10_000;
	localparam int US_TICK_US    = 1;
	localparam int CENTI_DIV_DEF = CENTI_TIME_US / US_TICK_US;

	// ----------------------------------------
	// Counter chain
	// ----------------------------------------
	localparam int         NUM_DIGITS = 7;
	localparam logic [3:0] DIGIT_ZERO = 4'h0;
	localparam logic [3:0] DIGIT_MAX  = 4'h9;

	// Gate lengths: centiseconds (frequency) or input cycles (period)
	localparam logic [9:0] GATE_N0 = 10'h001;
	localparam logic [9:0] GATE_N1 = 10'h00A;
	localparam logic [9:0] GATE_N2 = 10'h064;
	localparam logic [9:0] GATE_N3 = 10'h3E8;

	// Count of fractional digits right of the lit point
	localparam logic [2:0] DP_FREQ_BASE = 3'h1;
	localparam logic [2:0] DP_SECONDS   = 3'h2;
	localparam logic [2:0] DP_EVENTS    = 3'h0;

	// ----------------------------------------
	// Enumerations
	// ----------------------------------------
	typedef enum logic [1:0] {
		MODE_FREQ    = 2'b00,
		MODE_SECONDS = 2'b01,
		MODE_PERIOD  = 2'b10,
		MODE_EVENTS  = 2'b11
	} mode_type;

	typedef enum logic [1:0] {
		KNOB_RESET = 2'b00,
		KNOB_COUNT = 2'b01,
		KNOB_HOLD  = 2'b10
	} knob_type;

	typedef enum logic [1:0] {
		ST_CLEAR = 2'b00,
		ST_ARM   = 2'b01,
		ST_GATE  = 2'b10,
		ST_LATCH = 2'b11
	} state_type;

endpackage : mfc_pkg
`default_nettype wire

// ==== decade_digit.sv ====
`timescale 1ns/1ps
`default_nettype none
module decade_digit
	import mfc_pkg::*;
(
	input  wire logic       sys_clk, // Time-base clock
	input  wire logic       srst,    // Synchronous reset
	input  wire logic       clr,     // Clear digit to zero
	input  wire logic       inc,     // Advance by one
	output var  logic [3:0] digit_q, // BCD digit 1-2-4-8
	output wire logic       carry    // Wrap from nine to zero
);

	wire at_max = (digit_q == DIGIT_MAX);
	assign carry = inc & at_max & ~clr;

	always_ff @(posedge sys_clk) begin
		if (srst || clr) begin
			digit_q <= DIGIT_ZERO;
		end else if (inc) begin
			digit_q <= at_max ? DIGIT_ZERO : 4'(digit_q + 4'h1);
		end
	end

endmodule : decade_digit
`default_nettype wire

// ==== multifunction_decade_counter.sv ====
// Function
// - Frequency: count crossings over four gate times
// - Period: time-base ticks over 1-1000 cycles
// - Period LSD weight tracks cycles, 1 ns floor
// - Events totalize seven decades, overflow keeps counting
// - Stopwatch counts hundredths up to 99999.99
// - Decimal point from mode and range
// - Selector plus second choice picks four modes
// - Timing from 10 MHz reference, external option
// - Seven BCD digits, point, status out
// - Remote start/stop acts like manual gate
// - Gate and overflow annunciators driven
// - Manual modes follow reset, count, hold
// - Overflow stays lit until next reset or range/mode change in manual modes; auto modes relatch it each reading
// - Stopwatch advances 100 per second, gate lit
`timescale 1ns/1ps
`default_nettype none
module multifunction_decade_counter
	import mfc_pkg::*;
#(
	parameter int CENTI_DIV = CENTI_DIV_DEF // Microsecond ticks per 0.01 s
) (
	input  wire logic        sys_clk,         // 100 MHz clock
	input  wire logic        srst,            // Synchronous reset
	input  wire logic        sig_in,          // Conditioned input pulse train
	input  wire logic        ext_ref_in,      // External 10 MHz reference
	input  wire logic        ext_ref_sel,     // Use external reference
	input  wire logic        mode_switch,     // 0 freq/seconds, 1 period/events
	input  wire logic        manual_sel,      // Knob in manual positions
	input  wire logic [1:0]  range_sel,       // Gate time or cycle multiple
	input  wire logic [1:0]  knob_cmd,        // Reset, count, hold
	input  wire logic        remote_start,    // Remote start level
	input  wire logic        remote_stop,     // Remote stop level
	output var  logic [27:0] bcd_q,           // Seven BCD digits, digit 0 low
	output var  logic [2:0]  dp_pos_q,        // Fractional digit count
	output var  logic        gate_lamp_q,     // Input gated into counter
	output var  logic        overflow_lamp_q, // Capacity exceeded
	output var  logic [1:0]  mode_code_q,     // Active mode
	output var  logic        meas_done_q      // Auto reading latched
);

	// ----------------------------------------
	// Input synchronizers
	// ----------------------------------------
	logic [10:0] sync1_q;
	logic [10:0] sync2_q;
	logic [10:0] sync3_q;
	wire  [10:0] async_w = {sig_in, ext_ref_in, ext_ref_sel, mode_switch, manual_sel,
		range_sel, knob_cmd, remote_start, remote_stop};

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			sync1_q <= 11'h000;
			sync2_q <= 11'h000;
			sync3_q <= 11'h000;
		end else begin
			sync1_q <= async_w;
			sync2_q <= sync1_q;
			sync3_q <= sync2_q;
		end
	end

	wire       in_edge       = sync2_q[10] & ~sync3_q[10];
	wire       ext_edge      = sync2_q[9] & ~sync3_q[9];
	wire       ext_sel_s     = sync2_q[8];
	wire       manual_s      = sync2_q[6];
	wire [1:0] range_s       = sync2_q[5:4];
	wire [1:0] knob_s        = sync2_q[3:2];
	wire [1:0] knob_prev     = sync3_q[3:2];
	wire       rstart_edge   = sync2_q[1] & ~sync3_q[1];
	wire       rstop_edge    = sync2_q[0] & ~sync3_q[0];
	wire       cfg_change    = (sync2_q[7:4] != sync3_q[7:4]);
	mode_type  mode_s;
	assign mode_s = mode_type'(sync2_q[7:6]);

	// ----------------------------------------
	// Time base dividers
	// ----------------------------------------
	logic [3:0]  ref_div_q;
	logic [3:0]  us_div_q;
	logic [13:0] centi_div_q;

	wire int_tick   = (ref_div_q == 4'(REF_DIV - 1));
	wire ref_tick   = ext_sel_s ? ext_edge : int_tick;
	wire us_tick    = ref_tick & (us_div_q == 4'(US_DIV - 1));
	wire centi_tick = us_tick & (centi_div_q == 14'(CENTI_DIV - 1));

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ref_div_q   <= 4'h0;
			us_div_q    <= 4'h0;
			centi_div_q <= 14'h0000;
		end else begin
			ref_div_q <= int_tick ? 4'h0 : 4'(ref_div_q + 4'h1);
			if (ref_tick) begin
				us_div_q <= (us_div_q == 4'(US_DIV - 1)) ? 4'h0 : 4'(us_div_q + 4'h1);
			end
			if (us_tick) begin
				centi_div_q <= centi_tick ? 14'h0000 : 14'(centi_div_q + 14'h0001);
			end
		end
	end

	// ----------------------------------------
	// Manual gate: reset, count, hold
	// ----------------------------------------
	logic run_q;
	wire  manual_mode  = manual_s;
	wire  knob_reset   = (knob_s == KNOB_RESET);
	wire  knob_count_e = (knob_s == KNOB_COUNT) & (knob_prev != KNOB_COUNT);
	wire  knob_hold_e  = (knob_s != KNOB_COUNT) & (knob_prev == KNOB_COUNT);

	// Reset position overrides remote start so a cleared display stays put
	always_ff @(posedge sys_clk) begin
		if (srst || !manual_mode || knob_reset) begin
			run_q <= 1'b0;
		end else if (knob_count_e || rstart_edge) begin
			run_q <= 1'b1;
		end else if (knob_hold_e || rstop_edge) begin
			run_q <= 1'b0;
		end
	end

	// ----------------------------------------
	// Automatic measurement sequencer
	// ----------------------------------------
	state_type  state_q;
	state_type  state_d;
	logic [9:0] gate_cnt_q;

	wire [9:0] gate_target = (range_s == 2'b00) ? GATE_N0 :
	                         (range_s == 2'b01) ? GATE_N1 :
	                         (range_s == 2'b10) ? GATE_N2 : GATE_N3;
	wire is_freq   = (mode_s == MODE_FREQ);
	wire gate_step = is_freq ? centi_tick : in_edge;
	wire gate_last = gate_step & (gate_cnt_q == 10'(gate_target - 10'h001));

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_CLEAR: state_d = ST_ARM;
			ST_ARM:   state_d = gate_step ? ST_GATE : ST_ARM;
			ST_GATE:  state_d = gate_last ? ST_LATCH : ST_GATE;
			ST_LATCH: state_d = ST_CLEAR;
			default:  state_d = ST_CLEAR;
		endcase
		if (manual_mode || cfg_change) begin
			state_d = ST_CLEAR;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state_q    <= ST_CLEAR;
			gate_cnt_q <= 10'h000;
		end else begin
			state_q <= state_d;
			if (state_q != ST_GATE) begin
				gate_cnt_q <= 10'h000;
			end else if (gate_step) begin
				gate_cnt_q <= 10'(gate_cnt_q + 10'h001);
			end
		end
	end

	// ----------------------------------------
	// Decade chain
	// ----------------------------------------
	wire in_gate = (state_q == ST_GATE);
	wire cnt_clr = manual_mode ? (knob_reset | cfg_change) : (state_q == ST_CLEAR);
	wire inc_raw = (mode_s == MODE_FREQ)    ? (in_gate & in_edge) :
	               (mode_s == MODE_PERIOD)  ? (in_gate & us_tick) :
	               (mode_s == MODE_SECONDS) ? (run_q & centi_tick) :
	                                          (run_q & in_edge);
	wire cnt_inc = inc_raw & ~cnt_clr;

	wire [NUM_DIGITS:0]     carry_w;
	wire [4*NUM_DIGITS-1:0] count_w;
	assign carry_w[0] = cnt_inc;

	genvar gi;
	generate
		for (gi = 0; gi < NUM_DIGITS; gi++) begin : g_digit
			decade_digit u_digit (
				.sys_clk (sys_clk),
				.srst    (srst),
				.clr     (cnt_clr),
				.inc     (carry_w[gi]),
				.digit_q (count_w[4*gi +: 4]),
				.carry   (carry_w[gi+1])
			);
		end
	endgenerate

	// Sticky; a wrap in the clearing cycle cannot occur since inc is masked
	logic ovf_q;
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			ovf_q <= 1'b0;
		end else begin
			ovf_q <= carry_w[NUM_DIGITS] | (ovf_q & ~cnt_clr);
		end
	end

	// ----------------------------------------
	// Display and status outputs
	// ----------------------------------------
	wire [2:0] dp_sel = (mode_s == MODE_FREQ)    ? 3'(DP_FREQ_BASE + {1'b0, range_s}) :
	                    (mode_s == MODE_PERIOD)  ? {1'b0, range_s} :
	                    (mode_s == MODE_SECONDS) ? DP_SECONDS : DP_EVENTS;
	wire latch_now = (state_q == ST_LATCH);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			bcd_q           <= 28'h0000000;
			dp_pos_q        <= 3'h0;
			gate_lamp_q     <= 1'b0;
			overflow_lamp_q <= 1'b0;
			mode_code_q     <= 2'h0;
			meas_done_q     <= 1'b0;
		end else begin
			dp_pos_q    <= dp_sel;
			mode_code_q <= mode_s;
			gate_lamp_q <= manual_mode ? run_q : in_gate;
			meas_done_q <= latch_now & ~manual_mode;
			// Auto readings hold steady between gates; manual ones run live
			if (manual_mode || latch_now) begin
				bcd_q           <= count_w;
				overflow_lamp_q <= ovf_q;
			end
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_ref_div_period: assert property (@(posedge sys_clk) disable iff (srst)
		int_tick |=> (!int_tick)[*8] ##1 !int_tick ##1 int_tick)
		else $error("internal reference tick not every ten cycles");

	a_period_base: assert property (@(posedge sys_clk) disable iff (srst)
		(mode_s == MODE_PERIOD && cnt_inc) |-> (us_tick && in_gate))
		else $error("period count not on microsecond tick");

	a_gate_length: assert property (@(posedge sys_clk) disable iff (srst)
		(in_gate && state_d == ST_LATCH) |-> (gate_step && gate_cnt_q == gate_target - 10'h001))
		else $error("gate closed at wrong count");

	a_secs_rate: assert property (@(posedge sys_clk) disable iff (srst)
		(mode_s == MODE_SECONDS) |-> (cnt_inc == (run_q && centi_tick && !cnt_clr)))
		else $error("stopwatch not advancing on centisecond tick");

	a_ovf_set: assert property (@(posedge sys_clk) disable iff (srst)
		carry_w[NUM_DIGITS] |=> ovf_q ##1 (ovf_q || $past(cnt_clr)))
		else $error("overflow not flagged on wrap");

	a_ovf_sticky: assert property (@(posedge sys_clk) disable iff (srst)
		(ovf_q && !cnt_clr) |=> ovf_q)
		else $error("overflow dropped without reset");

	a_remote_start: assert property (@(posedge sys_clk) disable iff (srst)
		(manual_mode && !knob_reset && rstart_edge) |=> run_q ##1 gate_lamp_q)
		else $error("remote start ignored");

	a_reset_clears: assert property (@(posedge sys_clk) disable iff (srst)
		(manual_mode && knob_reset) |=> (!run_q && count_w == 28'h0000000))
		else $error("manual reset did not clear");

	a_secs_point: assert property (@(posedge sys_clk) disable iff (srst)
		(mode_s == MODE_SECONDS) |=> (dp_pos_q == DP_SECONDS))
		else $error("stopwatch point misplaced");

	a_latch_done: assert property (@(posedge sys_clk) disable iff (srst)
		(latch_now && !manual_mode) |=> (meas_done_q && bcd_q == $past(count_w)))
		else $error("auto reading not latched");

endmodule : multifunction_decade_counter
`default_nettype wire

// ==== remote_station.sv ====
`timescale 1ns/1ps
`default_nettype none
module remote_station (
	input  wire logic        sys_clk,      // Time-base clock
	input  wire logic [27:0] bcd_q,        // Parallel reading
	input  wire logic        meas_done_q,  // Reading latched
	output var  logic        remote_start, // Start level
	output var  logic        remote_stop   // Stop level
);
	logic [27:0] reading_q; // Last captured reading
	logic        done_q;
	initial begin
		remote_start = 1'b0;
		remote_stop  = 1'b0;
		done_q       = 1'b0;
	end
	// Take the reading one edge late, once the digits have settled
	always @(posedge sys_clk) begin
		done_q <= meas_done_q;
		if (done_q)
			reading_q <= bcd_q;
	end
	// Held for several cycles so the synchronisers see it
	task automatic press(input logic stop);
		@(posedge sys_clk);
		#1;
		if (stop)
			remote_stop = 1'b1;
		else
			remote_start = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		remote_start = 1'b0;
		remote_stop  = 1'b0;
	endtask : press
endmodule : remote_station
`default_nettype wire

// ==== multifunction_decade_counter_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module multifunction_decade_counter_tb;
	import mfc_pkg::*;
	localparam int CDIV = 5;
	typedef struct packed {
		logic [1:0]  mode;
		logic [1:0]  rng;
		logic        ext;
		logic [7:0]  half;
		logic [27:0] bcd;
		logic [2:0]  dp;
	} row_type;
	logic        sys_clk, srst, sig_in, ext_ref_in, ext_ref_sel, mode_switch, manual_sel;
	logic [1:0]  range_sel, knob_cmd;
	logic [7:0]  half, cnt;
	logic [27:0] held;
	wire  logic  remote_start, remote_stop, gate_lamp_q, overflow_lamp_q, meas_done_q;
	wire  logic [27:0] bcd_q;
	wire  logic [2:0]  dp_pos_q;
	wire  logic [1:0]  mode_code_q;
	int          failures, checks;
	// Gate lengths are whole multiples of the input period, so counts are exact
	row_type rows [6] = '{
		'{2'b00, 2'h0, 1'b0, 8'h0A, 28'h25, 3'h1},
		'{2'b00, 2'h1, 1'b0, 8'h0A, 28'h250, 3'h2},
		'{2'b00, 2'h0, 1'b1, 8'h0A, 28'h50, 3'h1},
		'{2'b10, 2'h0, 1'b0, 8'h64, 28'h2, 3'h0},
		'{2'b10, 2'h1, 1'b0, 8'h64, 28'h20, 3'h1},
		'{2'b10, 2'h0, 1'b1, 8'h64, 28'h1, 3'h0}};

	multifunction_decade_counter #(.CENTI_DIV(CDIV)) u_multifunction_decade_counter (
		.sys_clk(sys_clk), .srst(srst), .sig_in(sig_in), .ext_ref_in(ext_ref_in),
		.ext_ref_sel(ext_ref_sel), .mode_switch(mode_switch), .manual_sel(manual_sel),
		.range_sel(range_sel), .knob_cmd(knob_cmd), .remote_start(remote_start),
		.remote_stop(remote_stop), .bcd_q(bcd_q), .dp_pos_q(dp_pos_q),
		.gate_lamp_q(gate_lamp_q), .overflow_lamp_q(overflow_lamp_q),
		.mode_code_q(mode_code_q), .meas_done_q(meas_done_q));
	remote_station u_remote_station (
		.sys_clk(sys_clk), .bcd_q(bcd_q), .meas_done_q(meas_done_q),
		.remote_start(remote_start), .remote_stop(remote_stop));

	// ----
	// Stimulus sources
	// ----
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	// Offset phase keeps the external reference unrelated to sys_clk
	// Half the internal rate, so a select that is ignored shows in the readings
	initial begin
		ext_ref_in = 1'b0;
		#3;
		forever #100 ext_ref_in = ~ext_ref_in;
	end
	always @(posedge sys_clk) if (half != 8'h00) begin
		cnt <= (cnt + 8'h01 >= half) ? 8'h00 : cnt + 8'h01;
		if (cnt + 8'h01 >= half)
			sig_in <= #1 ~sig_in;
	end

	// ----
	// Tasks
	// ----
	task automatic check(input string name, input logic [27:0] seen, input logic [27:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : check
	task automatic conclude;
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : conclude
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : cyc
	task automatic wait_done(input int n);
		int k;
		k = 0;
		while (n > 0 && k < 30000) begin
			cyc(1);
			k++;
			if (meas_done_q === 1'b1)
				n--;
		end
		check("meas_done", 28'(n), 28'h0);
		cyc(3);
	endtask : wait_done
	task automatic wait_bcd(input logic [27:0] v);
		int k;
		k = 0;
		while (bcd_q !== v && k < 2000) begin
			cyc(1);
			k++;
		end
		check("bcd_wait", bcd_q, v);
	endtask : wait_bcd
	task automatic pulses(input int n);
		repeat (n) begin
			sig_in = 1'b1;
			cyc(4);
			sig_in = 1'b0;
			cyc(4);
		end
		cyc(6);
	endtask : pulses
	task automatic set_mode(input logic [1:0] m, input knob_type k);
		{mode_switch, manual_sel} = m;
		knob_cmd = k;
		cyc(10);
	endtask : set_mode

	initial begin
		repeat (60000) @(posedge sys_clk);
		failures++;
		conclude();
	end

	// ----
	// Main sequence
	// ----
	initial begin
		{srst, sig_in, ext_ref_sel, mode_switch, manual_sel} = 5'b10000;
		{range_sel, knob_cmd, half, cnt} = '0;
		failures = 0;
		checks = 0;
		cyc(10);
		srst = 1'b0;
		cyc(1);
		check("reset_out", {bcd_q[23:0], gate_lamp_q, overflow_lamp_q, mode_code_q}, 28'h0);
		$display("test reset done");
		foreach (rows[i]) begin
			{mode_switch, manual_sel} = rows[i].mode;
			range_sel = rows[i].rng;
			ext_ref_sel = rows[i].ext;
			half = rows[i].half;
			wait_done(3);
			check("reading", u_remote_station.reading_q, rows[i].bcd);
			check("dp_pos", 28'(dp_pos_q), 28'(rows[i].dp));
			check("mode_code", 28'(mode_code_q), 28'(rows[i].mode));
			check("overflow", 28'(overflow_lamp_q), 28'h0);
		end
		$display("test auto rows done");
		half = 8'h00;
		ext_ref_sel = 1'b0;
		set_mode(2'b01, KNOB_RESET);
		check("sec_clear", {bcd_q[26:0], gate_lamp_q}, 28'h0);
		knob_cmd = KNOB_COUNT;
		wait_bcd(28'h1);
		cyc(CDIV * 50);
		check("sec_mid", bcd_q, 28'h1);
		cyc(CDIV * 100);
		check("sec_next", bcd_q, 28'h2);
		check("sec_gate", 28'(gate_lamp_q), 28'h1);
		check("sec_dp", 28'(dp_pos_q), 28'h2);
		knob_cmd = KNOB_HOLD;
		cyc(10);
		held = bcd_q;
		cyc(1000);
		check("sec_hold", bcd_q, held);
		check("hold_gate", 28'(gate_lamp_q), 28'h0);
		u_remote_station.press(1'b0);
		cyc(6);
		check("remote_start", 28'(gate_lamp_q), 28'h1);
		u_remote_station.press(1'b1);
		cyc(6);
		check("remote_stop", 28'(gate_lamp_q), 28'h0);
		$display("test seconds done");
		sig_in = 1'b0;
		set_mode(2'b11, KNOB_RESET);
		knob_cmd = KNOB_COUNT;
		cyc(6);
		pulses(12);
		check("events", bcd_q, 28'h12);
		check("ev_dp", 28'(dp_pos_q), 28'h0);
		knob_cmd = KNOB_HOLD;
		cyc(6);
		pulses(3);
		check("ev_hold", bcd_q, 28'h12);
		knob_cmd = KNOB_RESET;
		cyc(6);
		check("ev_reset", {bcd_q[26:0], gate_lamp_q}, 28'h0);
		$display("test events done");
		conclude();
	end
endmodule : multifunction_decade_counter_tb
`default_nettype wire
